// >>> rtl/plt_map.vh
`ifndef PLT_MAP_VH
`define PLT_MAP_VH

// register byte offsets
`define PLT_CTRL        8'h00
`define PLT_HYST        8'h04
`define PLT_THRESH      8'h08
`define PLT_ONTIME      8'h0C
`define PLT_ONTIME_OBJ  8'h10
`define PLT_REPEAT      8'h14
`define PLT_SAFETY      8'h18
`define PLT_STATUS      8'h1C

// control fields
`define PLT_CTRL_SLAVE  0
`define PLT_CTRL_INDEP  1
`define PLT_CTRL_OBJEN  2
`define PLT_CTRL_RST    3'h2

// limits and reset values
`define PLT_HYST_MIN    16'h000F
`define PLT_HYST_MAX    16'h01F4
`define PLT_HYST_RST    16'h003C
`define PLT_THRESH_RST  16'h2CE2
`define PLT_ONTIME_MIN  16'h000A
`define PLT_ONTIME_MAX  16'hFFFF
`define PLT_ONTIME_RST  16'h012C
`define PLT_REPEAT_MIN  16'h000A
`define PLT_REPEAT_MAX  16'hFFFF
`define PLT_REPEAT_RST  16'h001E
`define PLT_SAFETY_MIN  16'h0064
`define PLT_SAFETY_MAX  16'hEA5F
`define PLT_SAFETY_RST  16'h04E2

// timing
`define PLT_CLK_HZ      40000000
`define PLT_TICK_MS     1
`define PLT_MS_CYCLES   (`PLT_CLK_HZ / 1000 * `PLT_TICK_MS)
`define PLT_SEC_MS      1000

`endif

// >>> rtl/plt_timer.v
`timescale 1ns/1ps
`default_nettype none

// retriggerable down counter, one-cycle done pulse when the count runs out
module plt_timer #(
  parameter W = 16
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire         load,
  input  wire         stop,
  input  wire [W-1:0] load_val,
  input  wire         tick,
  output reg          running,
  output reg          done
);

  reg [W-1:0] cnt;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= {W{1'b0}};
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt     <= load_val;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/plt_top.v
// Behaviour
// [RULE_01] switch around threshold with percentage hysteresis band
// [RULE_02] light-on delay expiry sends switch-off value
// [RULE_03] delay starts counting when motion ends
// [RULE_04] renewed motion restarts delay from full
// [RULE_05] object light-on time saturates to 10..65535
// [RULE_06] slave repeats presence only while motion present
// [RULE_07] slave repeat shorter than master light-on time; not enforced, repeat_s and ontime are each clamped to 10..65535 on their own
// [RULE_08] safety time after switch-off ignores detection
// [RULE_09] threshold written as 2-byte float lux
// [RULE_10] all switching goes via presence output
// [RULE_11] slave mode sends only periodic ON telegrams
// [RULE_12] no telegram when bright above threshold; code gates only the switch-on, and not while ctrl INDEP bit is set
// [RULE_13] timers count common ms and second ticks
`timescale 1ns/1ps
`default_nettype none
`include "plt_map.vh"

module plt_top #(
  parameter ADDR_W    = 8,
  parameter MS_CYCLES = `PLT_MS_CYCLES,
  parameter SEC_TICKS = `PLT_SEC_MS
) (
  input  wire              ref_clk,
  input  wire              rst_n,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              motion,
  input  wire [15:0]       brightness,
  output reg               presence_tx,
  output reg               presence_on
);

  localparam S_IDLE  = 2'd0;
  localparam S_ON    = 2'd1;
  localparam S_DELAY = 2'd2;
  localparam S_SAFE  = 2'd3;

  reg  [2:0]        ctrl;
  reg  [15:0]       hyst;
  reg  [15:0]       thresh;
  reg  [15:0]       ontime;
  reg  [15:0]       repeat_s;
  reg  [15:0]       safety;
  reg  [ADDR_W-1:0] aw_addr;
  reg               aw_hold;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;
  reg               w_hold;
  reg  [31:0]       ms_cnt;
  reg  [15:0]       sec_cnt;
  reg               ms_tick;
  reg               sec_tick;
  reg               dark;
  reg  [1:0]        state;
  reg               mode_slave;
  reg               delay_load;
  reg               safe_load;
  reg               rep_load;
  reg               stop_all;
  wire              delay_done;
  wire              safe_done;
  wire              rep_done;
  wire [31:0]       wd;
  wire [7:0]        wa;
  wire              allowed;
  wire [26:0]       thr_centilux;
  wire [39:0]       b_scaled;
  wire [39:0]       hi_lim;
  wire [39:0]       lo_lim;

  function [15:0] clamp;
    input [31:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < {16'h0000, lo})
        clamp = lo;
      else if (v > {16'h0000, hi})
        clamp = hi;
      else
        clamp = v[15:0];
    end
  endfunction

  // partial writes keep the untouched low lanes of the register
  function [31:0] merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge = {s[3] ? d[31:24] : 8'h00, s[2] ? d[23:16] : 8'h00,
               s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  assign wa = {{(8 - ADDR_W){1'b0}}, aw_addr} & 8'hFC;

  reg [15:0] wold;
  always @* begin
    case (wa)
      `PLT_CTRL:       wold = {13'h0000, ctrl};
      `PLT_HYST:       wold = hyst;
      `PLT_THRESH:     wold = thresh;
      `PLT_ONTIME:     wold = ontime;
      `PLT_ONTIME_OBJ: wold = ontime;
      `PLT_REPEAT:     wold = repeat_s;
      `PLT_SAFETY:     wold = safety;
      default:         wold = 16'h0000;
    endcase
  end
  assign wd = merge(wold, w_data, w_strb);

  // AXI4-Lite write: address and data taken in either order, response after both
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      ctrl          <= `PLT_CTRL_RST;
      hyst          <= `PLT_HYST_RST;
      thresh        <= `PLT_THRESH_RST;
      ontime        <= `PLT_ONTIME_RST;
      repeat_s      <= `PLT_REPEAT_RST;
      safety        <= `PLT_SAFETY_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_hold       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_hold       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (wa)
          `PLT_CTRL:   ctrl <= wd[2:0];
          `PLT_HYST:   hyst <= clamp(wd, `PLT_HYST_MIN, `PLT_HYST_MAX); // [RULE_01]
          `PLT_THRESH: thresh <= wd[15:0]; // [RULE_09]
          `PLT_ONTIME: ontime <= clamp(wd, `PLT_ONTIME_MIN, `PLT_ONTIME_MAX);
          `PLT_ONTIME_OBJ: begin
            if (ctrl[`PLT_CTRL_OBJEN])
              ontime <= clamp(wd, `PLT_ONTIME_MIN, `PLT_ONTIME_MAX); // [RULE_05]
          end
          `PLT_REPEAT: repeat_s <= clamp(wd, `PLT_REPEAT_MIN, `PLT_REPEAT_MAX);
          `PLT_SAFETY: safety <= clamp(wd, `PLT_SAFETY_MIN, `PLT_SAFETY_MAX);
          `PLT_STATUS: s_axi_bresp <= 2'b00;
          default:     s_axi_bresp <= 2'b10;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'b00;
        case ({{(8 - ADDR_W){1'b0}}, s_axi_araddr} & 8'hFC)
          `PLT_CTRL:       s_axi_rdata <= {29'h0, ctrl};
          `PLT_HYST:       s_axi_rdata <= {16'h0, hyst};
          `PLT_THRESH:     s_axi_rdata <= {16'h0, thresh};
          `PLT_ONTIME:     s_axi_rdata <= {16'h0, ontime};
          `PLT_ONTIME_OBJ: s_axi_rdata <= {16'h0, ontime};
          `PLT_REPEAT:     s_axi_rdata <= {16'h0, repeat_s};
          `PLT_SAFETY:     s_axi_rdata <= {16'h0, safety};
          `PLT_STATUS:     s_axi_rdata <= {26'h0, presence_on, motion, dark, mode_slave, state};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // shared tick dividers: one-cycle ms and second enables
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt   <= 32'h0000_0000;
      sec_cnt  <= 16'h0000;
      ms_tick  <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      ms_tick  <= 1'b0;
      sec_tick <= 1'b0;
      if (ms_cnt >= MS_CYCLES - 1) begin
        ms_cnt  <= 32'h0000_0000;
        ms_tick <= 1'b1; // [RULE_13]
        if (sec_cnt >= SEC_TICKS - 1) begin
          sec_cnt  <= 16'h0000;
          sec_tick <= 1'b1; // [RULE_13]
        end else begin
          sec_cnt <= sec_cnt + 16'h0001;
        end
      end else begin
        ms_cnt <= ms_cnt + 32'h0000_0001;
      end
    end
  end

  // threshold float: sign bit 15, exponent 14:11, mantissa 10:0, unit 0.01 lux;
  // a negative threshold is treated as zero
  assign thr_centilux = thresh[15] ? 27'h0 : ({16'h0000, thresh[10:0]} << thresh[14:11]);
  assign b_scaled = {24'h0, brightness} * 40'd10000;
  assign hi_lim   = {13'h0, thr_centilux} * ({24'h0, hyst} + 40'd100);
  assign lo_lim   = (hyst >= 16'd100) ? 40'h0 : {13'h0, thr_centilux} * (40'd100 - {24'h0, hyst});

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      dark <= 1'b1;
    else if (b_scaled < lo_lim)
      dark <= 1'b1; // [RULE_01]
    else if (b_scaled > hi_lim)
      dark <= 1'b0; // [RULE_01]
  end

  assign allowed = ctrl[`PLT_CTRL_INDEP] | dark; // [RULE_12]

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= S_IDLE;
      mode_slave  <= 1'b0;
      presence_tx <= 1'b0;
      presence_on <= 1'b0;
      delay_load  <= 1'b0;
      safe_load   <= 1'b0;
      rep_load    <= 1'b0;
      stop_all    <= 1'b0;
    end else begin
      presence_tx <= 1'b0;
      delay_load  <= 1'b0;
      safe_load   <= 1'b0;
      rep_load    <= 1'b0;
      stop_all    <= 1'b0;
      mode_slave  <= ctrl[`PLT_CTRL_SLAVE];
      if (mode_slave != ctrl[`PLT_CTRL_SLAVE]) begin
        // a mode change abandons any running sequence
        state    <= S_IDLE;
        stop_all <= 1'b1;
      end else begin
        case (state)
          S_IDLE: begin
            if (motion && allowed) begin // [RULE_12]
              presence_tx <= 1'b1; // [RULE_10]
              presence_on <= 1'b1;
              rep_load    <= mode_slave; // [RULE_06]
              state       <= S_ON;
            end
          end
          S_ON: begin
            if (mode_slave) begin
              if (!motion) begin
                stop_all <= 1'b1; // [RULE_06]
                state    <= S_IDLE;
              end else if (rep_done) begin
                presence_tx <= 1'b1; // [RULE_11]
                presence_on <= 1'b1;
                rep_load    <= 1'b1;
              end
            end else if (!motion) begin
              delay_load <= 1'b1; // [RULE_03]
              state      <= S_DELAY;
            end
          end
          S_DELAY: begin
            if (motion) begin
              stop_all <= 1'b1; // [RULE_04]
              state    <= S_ON;
            end else if (delay_done) begin
              presence_tx <= 1'b1; // [RULE_02]
              presence_on <= 1'b0;
              safe_load   <= 1'b1; // [RULE_08]
              state       <= S_SAFE;
            end
          end
          S_SAFE: begin
            if (safe_done)
              state <= S_IDLE; // [RULE_08]
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  plt_timer #(.W(16)) u_delay (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .load     (delay_load),
    .stop     (stop_all),
    .load_val (ontime),
    .tick     (sec_tick),
    .running  (),
    .done     (delay_done)
  );

  plt_timer #(.W(16)) u_safety (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .load     (safe_load),
    .stop     (1'b0),
    .load_val (safety),
    .tick     (ms_tick),
    .running  (),
    .done     (safe_done)
  );

  plt_timer #(.W(16)) u_repeat (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .load     (rep_load),
    .stop     (stop_all),
    .load_val (repeat_s),
    .tick     (sec_tick),
    .running  (),
    .done     (rep_done)
  );

endmodule

`default_nettype wire

// >>> verification/plt_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module plt_top_props #(
  parameter MS_CYCLES = 4
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       motion,
  input wire logic       presence_tx,
  input wire logic       presence_on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // saturates so a long idle spell never wraps into a false gap
  int since_off;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      since_off <= 32'h7FFF_FFFF;
    else if (presence_tx && !presence_on)
      since_off <= 0;
    else if (since_off < 32'h7FFF_FFFF)
      since_off <= since_off + 1;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_no_off;
    !(presence_tx && !presence_on) [*8];
  endsequence
  AST_TX_PULSE: assert property (presence_tx |=> !presence_tx)
    else $error("telegram pulse too long");
  AST_ON_CHANGE: assert property ($changed(presence_on) |-> presence_tx)
    else $error("value changed without telegram");
  AST_ON_MOTION: assert property (presence_tx && presence_on |-> $past(motion))
    else $error("on telegram without motion");
  AST_NO_OFF: assert property (motion |=> s_no_off)
    else $error("off telegram during motion");
  AST_SAFETY: assert property (presence_tx && presence_on |-> since_off >= 99 * MS_CYCLES)
    else $error("on telegram inside safety time");
  AST_WR_LAT: assert property (s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
endmodule
bind plt_top plt_top_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .motion(motion),
  .presence_tx(presence_tx), .presence_on(presence_on)
);
`default_nettype wire

// >>> verification/plt_bus_sink.sv
`timescale 1ns/1ps
`default_nettype none
module plt_bus_sink (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic presence_tx,
  input  wire logic presence_on,
  output var  logic rx_valid,
  output var  logic rx_val
);
  // the bus delivers each telegram one cycle after launch
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_val   <= 1'b0;
    end else begin
      rx_valid <= presence_tx;
      rx_val   <= presence_on;
    end
  end
endmodule
`default_nettype wire

// >>> verification/plt_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int MSC = 4;
  localparam int SEC = MSC * 5;
  localparam int ONT = 12;
  logic        ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, motion;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rng, d;
  logic [15:0] brightness;
  logic [3:0]  wstrb;
  logic [1:0]  r;
  wire         awready, wready, bvalid, arready, rvalid, ptx, pon, rx_valid, rx_val;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          miscompares, checked, cyc, ntel, t_last, t0, k;
  logic        q[$];
  logic [31:0] rt[8][2] = '{'{32'h0, 32'h2}, '{32'h4, 32'h3C}, '{32'h8, 32'h2CE2}, '{32'hC, 32'h12C},
                            '{32'h14, 32'h1E}, '{32'h18, 32'h4E2}, '{32'h1C, 32'h8}, '{32'h20, 32'h0}};
  logic [31:0] wt[13][3] = '{'{32'h4, 32'h258, 32'h1F4}, '{32'h4, 32'h5, 32'hF}, '{32'hC, 32'h3, 32'hA},
    '{32'h18, 32'h1, 32'h64}, '{32'h18, 32'hFFFF, 32'hEA5F}, '{32'h18, 32'h0, 32'h64},
    '{32'h14, 32'h10000, 32'hFFFF}, '{32'h14, 32'h5, 32'hA}, '{32'h10, 32'h14, 32'hA},
    '{32'h0, 32'h6, 32'h6}, '{32'h10, 32'h20000, 32'hFFFF}, '{32'h10, 32'h3, 32'hA}, '{32'h10, 32'hC, 32'hC}};

  plt_top #(.MS_CYCLES(MSC), .SEC_TICKS(5)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .motion(motion), .brightness(brightness), .presence_tx(ptx), .presence_on(pon));
  plt_bus_sink sink_u (.ref_clk(ref_clk), .rst_n(rst_n), .presence_tx(ptx), .presence_on(pon),
    .rx_valid(rx_valid), .rx_val(rx_val));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    awaddr  <= a[7:0];
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    // a late bready now and then makes the slave hold its response
    rng = xs(rng);
    bready  <= rng[0];
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge ref_clk);
    araddr  <= a[7:0];
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic mv(input logic v, input int n);
    @(posedge ref_clk);
    motion <= v;
    repeat (n) @(posedge ref_clk);
  endtask
  // the global cycle limit is what ends a telegram that never comes
  task automatic wait_tel(input int n);
    while (ntel < n) @(posedge ref_clk);
  endtask

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run;
    end
    if (rst_n && rx_valid) begin
      ntel++;
      t_last = cyc;
      chk(rx_val, q.size() ? q.pop_front() : 2'h2);
    end
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, motion} = 7'h0;
    {awaddr, araddr, wdata, brightness} = 64'h0;
    wstrb = 4'hF;
    rng = 32'hCDDB;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rt[i]) begin
      rd(rt[i][0]);
      chk(d, rt[i][1]);
    end
    chk(r, 2'h2);
    wr(32'h24, 32'h1);
    chk(r, 2'h2);
    // low lanes merge with the old value, upper lanes never land
    wstrb <= 4'h1;
    wr(32'h4, 32'h1234_5678);
    rd(32'h4);
    chk(d, 32'h78);
    wstrb <= 4'h2;
    wr(32'h4, 32'hFFFF_0100);
    rd(32'h4);
    chk(d, 32'h178);
    wstrb <= 4'hF;
    foreach (wt[i]) begin
      wr(wt[i][0], wt[i][1]);
      rd(wt[i][0] == 32'h10 ? 32'hC : wt[i][0]);
      chk(d, wt[i][2]);
    end
    q.push_back(1'b1);
    rng = xs(rng);
    mv(1'b1, (ONT + 3) * SEC + rng[4:0]);
    mv(1'b0, 5 * SEC);
    mv(1'b1, 3);
    q.push_back(1'b0);
    k = ntel + 1;
    mv(1'b0, 0);
    t0 = cyc;
    wait_tel(k);
    chk(t_last - t0 >= (ONT - 1) * SEC && t_last - t0 <= ONT * SEC + 8, 1'b1);
    rng = xs(rng);
    mv(1'b1, 20 + rng[5:0]);
    mv(1'b0, 100 * MSC + 20);
    q.push_back(1'b1);
    q.push_back(1'b0);
    k = ntel + 2;
    mv(1'b1, 4);
    mv(1'b0, 0);
    wait_tel(k);
    mv(1'b0, 100 * MSC + 20);
    wr(32'h0, 32'h3);
    repeat (3) q.push_back(1'b1);
    mv(1'b1, 25 * SEC);
    mv(1'b0, 15 * SEC);
    chk(q.size(), 32'h0);
    wr(32'h0, 32'h0);
    rng = xs(rng);
    brightness <= 16'h1F4 + rng[9:0];
    mv(1'b0, 4);
    mv(1'b1, 10);
    rng = xs(rng);
    brightness <= {8'h0, rng[7:0]};
    q.push_back(1'b1);
    q.push_back(1'b0);
    k = ntel + 2;
    mv(1'b0, 4);
    mv(1'b1, 4);
    mv(1'b0, 0);
    wait_tel(k);
    chk(q.size(), 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
